// ---- pkg/acr_pkg.sv ----
// Constants, field layout and types of the converter configuration register
package acr_pkg;
  localparam int unsigned ACR_WORD_BITS = 16;
  localparam int unsigned ACR_FRAME_BITS = 32;
  localparam logic [15:0] ACR_CFG_RESET = 16'h058B;
  localparam int unsigned ACR_SS_BIT = 15;
  localparam int unsigned ACR_MUX_LSB = 12;
  localparam int unsigned ACR_GAIN_LSB = 9;
  localparam int unsigned ACR_MODE_BIT = 8;
  localparam int unsigned ACR_RATE_LSB = 5;
  localparam int unsigned ACR_TEMP_BIT = 4;
  localparam int unsigned ACR_PULLUP_BIT = 3;
  localparam int unsigned ACR_QUAL_LSB = 1;
  localparam int unsigned ACR_RSVD_BIT = 0;
  localparam logic [1:0] ACR_QUAL_VALID = 2'h1;
  localparam logic ACR_RSVD_VALUE = 1'h1;
  localparam logic ACR_SS_READ = 1'h0;
  localparam logic [5:0] ACR_LAST_WORD_BIT = 6'h0F;
  localparam logic [5:0] ACR_FRAME_END = 6'h20;
  localparam logic [15:0] ACR_RESULT_RESET = 16'h0000;
  localparam real ACR_CLK_PERIOD_NS = 8.0;

  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'b01,
    ACR_ST_CONV = 2'b10
  } acr_state_t;
endpackage

// ---- pkg/acr_link_if.sv ----
// Carrier between the serial link logic and the system-side register logic
`timescale 1ns/1ps
interface acr_link_if;
  logic [15:0] cfg_word;
  logic cfg_tog;
  logic [15:0] result;

  modport link (output cfg_word, output cfg_tog, input result);
  modport core (input cfg_word, input cfg_tog, output result);
endinterface

// ---- logic/acr_spi_link.sv ----
// Serial link shifter on the link clock: word capture, readback, data out
`timescale 1ns/1ps
module acr_spi_link
  import acr_pkg::*;
(
  // Reset
  input wire logic sys_rst_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  // Towards the system side
  acr_link_if.link lk
);
  logic frm_rst;
  logic [5:0] cnt_q;
  logic [14:0] sh_q;
  logic [15:0] full_w;
  logic [15:0] shadow_q;
  logic [15:0] word_q;
  logic tog_q;
  logic dout_q;

  // Frame logic restarts whenever select goes high, so a cut frame leaves nothing behind
  assign frm_rst = sys_rst_i | cs_n_i;
  assign full_w = {sh_q, din_i};

  always_ff @(negedge sclk_i or posedge frm_rst) begin
    if (frm_rst) begin
      cnt_q <= 6'h00;
      sh_q <= 15'h0000;
    end else begin
      sh_q <= full_w[14:0];
      if (cnt_q != ACR_FRAME_END) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // Shadow tracks the system copy exactly, since only this link ever changes it
  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_q <= 16'h0000;
      tog_q <= 1'b0;
      shadow_q <= ACR_CFG_RESET;
    end else if (!cs_n_i && cnt_q == ACR_LAST_WORD_BIT) begin
      word_q <= full_w;
      tog_q <= ~tog_q;
      if (full_w[ACR_QUAL_LSB +: 2] == ACR_QUAL_VALID) begin
        shadow_q <= {ACR_SS_READ, full_w[14:1], ACR_RSVD_VALUE};
      end
    end
  end

  always_ff @(posedge sclk_i or posedge frm_rst) begin
    if (frm_rst) begin
      dout_q <= 1'b1;
    end else if (cnt_q[5]) begin
      dout_q <= 1'b1;
    end else if (cnt_q[4]) begin
      dout_q <= shadow_q[~cnt_q[3:0]];
    end else begin
      dout_q <= lk.result[~cnt_q[3:0]];
    end
  end

  assign dout_o = dout_q;
  assign lk.cfg_word = word_q;
  assign lk.cfg_tog = tog_q;

  chk_short_frame: assert property (
    @(negedge sclk_i) disable iff (sys_rst_i)
    (cs_n_i || cnt_q != ACR_LAST_WORD_BIT) |=> $stable(tog_q))
    else $error("word handed over before sixteen bits");

  chk_readback_word: assert property (
    @(negedge sclk_i) disable iff (sys_rst_i)
    (!cs_n_i && cnt_q == ACR_LAST_WORD_BIT &&
     full_w[ACR_QUAL_LSB +: 2] == ACR_QUAL_VALID)
    |=> shadow_q == {ACR_SS_READ, $past(full_w[14:1]), ACR_RSVD_VALUE})
    else $error("readback differs from word written");
endmodule // acr_spi_link

// ---- logic/acr_config.sv ----
// Converter configuration register with serial link and conversion control
`timescale 1ns/1ps
// Contract
// - Configuration resets to 058B hex, every field at its default.
// - Writing one-shot bit as 1 while powered down starts exactly one conversion.
// - One-shot write during a running conversion is ignored.
// - One-shot bit always reads back as zero.
// - Bits 14:12 choose input pair; 000 default, 1xx against ground.
// - Bits 11:9 choose full-scale range; 010 default is 2.048 V.
// - Bit 8: 0 continuous, 1 power-down single-shot (default).
// - Bits 7:5 choose output rate 128 to 3300 per second; 100 default.
// - Bit 4 selects temperature sensor instead of analog inputs.
// - Bit 3 enables weak pull-up on data-out pin only while select high.
// - Shifted word updates register only when bits 2:1 equal 01.
// - Qualifier 00, 10 or 11 leaves every field unchanged.
// - Bit 0 ignores writes and always reads one.
// - Data-in sampled on falling clock edges while result shifts out MSB first.
// - Second half of 32-bit frame returns configuration written in first half.
// - Continuous mode starts conversions back to back, even with select high.
module acr_config
  import acr_pkg::*;
(
  // System clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  output logic pullup_en_o,
  // Converter core
  input wire logic conv_done_i,
  input wire logic [15:0] result_i,
  output logic conv_start_o,
  output logic converting_o,
  // Decoded settings
  output logic [15:0] cfg_o,
  output logic [1:0] mux_pos_o,
  output logic [1:0] mux_neg_o,
  output logic mux_neg_gnd_o,
  output logic [12:0] full_scale_mv_o,
  output logic [11:0] rate_sps_o,
  output logic rate_valid_o,
  output logic temp_sel_o,
  output logic cont_mode_o
);
  acr_link_if lk ();

  logic cs_s1_q;
  logic cs_s2_q;
  logic tg_s1_q;
  logic tg_s2_q;
  logic tg_s3_q;
  logic new_word;
  logic qual_ok;
  logic apply;
  logic ss_req;
  logic start;
  logic [15:0] cfg_q;
  logic [15:0] result_q;
  logic start_q;
  logic pullup_q;
  acr_state_t state_q;
  logic [1:0] mux_pos_q;
  logic [1:0] mux_neg_q;
  logic mux_gnd_q;
  logic [12:0] fs_q;
  logic [11:0] rate_q;
  logic rate_ok_q;

  acr_spi_link u_link (
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .dout_o(dout_o),
    .lk(lk.link)
  );

  // Driver stays on only while selected; the pin is otherwise released
  assign dout_oe_n_o = cs_n_i;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
    end
  end

  // Toggle crossing; the word itself is held still for a whole word time after the toggle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end else begin
      tg_s1_q <= lk.cfg_tog;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  assign new_word = tg_s2_q ^ tg_s3_q;
  assign qual_ok = (lk.cfg_word[ACR_QUAL_LSB +: 2] == ACR_QUAL_VALID);
  assign apply = new_word & qual_ok;
  assign ss_req = apply & lk.cfg_word[ACR_SS_BIT] & lk.cfg_word[ACR_MODE_BIT];
  assign start = (state_q == ACR_ST_IDLE) & (ss_req | ~cfg_q[ACR_MODE_BIT]);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q <= ACR_CFG_RESET;
    end else if (apply) begin
      cfg_q <= {ACR_SS_READ, lk.cfg_word[14:1], ACR_RSVD_VALUE};
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ACR_ST_IDLE;
      start_q <= 1'b0;
    end else begin
      start_q <= start;
      unique case (state_q)
        ACR_ST_IDLE: begin
          if (start) begin
            state_q <= ACR_ST_CONV;
          end
        end
        ACR_ST_CONV: begin
          if (conv_done_i) begin
            state_q <= ACR_ST_IDLE;
          end
        end
        default: begin
          state_q <= ACR_ST_IDLE;
        end
      endcase
    end
  end

  // Result is only replaced while the link is idle; a result landing mid-frame is dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_q <= ACR_RESULT_RESET;
    end else if (conv_done_i && cs_s2_q) begin
      result_q <= result_i;
    end
  end

  assign lk.result = result_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pullup_q <= ACR_CFG_RESET[ACR_PULLUP_BIT];
    end else begin
      pullup_q <= cs_s2_q & cfg_q[ACR_PULLUP_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mux_pos_q <= 2'h0;
      mux_neg_q <= 2'h1;
      mux_gnd_q <= 1'b0;
    end else begin
      mux_gnd_q <= cfg_q[14];
      if (cfg_q[14]) begin
        mux_pos_q <= cfg_q[13:12];
        mux_neg_q <= 2'h0;
      end else if (cfg_q[13:12] == 2'h0) begin
        mux_pos_q <= 2'h0;
        mux_neg_q <= 2'h1;
      end else begin
        mux_pos_q <= cfg_q[13:12] - 2'h1;
        mux_neg_q <= 2'h3;
      end
    end
  end

  // Unlisted gain code 110 is treated like its neighbours at the smallest range
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fs_q <= 13'h0800;
    end else begin
      unique case (cfg_q[ACR_GAIN_LSB +: 3])
        3'h0: fs_q <= 13'h1800;
        3'h1: fs_q <= 13'h1000;
        3'h2: fs_q <= 13'h0800;
        3'h3: fs_q <= 13'h0400;
        3'h4: fs_q <= 13'h0200;
        default: fs_q <= 13'h0100;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rate_q <= 12'h640;
      rate_ok_q <= 1'b1;
    end else begin
      rate_ok_q <= (cfg_q[ACR_RATE_LSB +: 3] != 3'h7);
      unique case (cfg_q[ACR_RATE_LSB +: 3])
        3'h0: rate_q <= 12'h080;
        3'h1: rate_q <= 12'h0FA;
        3'h2: rate_q <= 12'h1EA;
        3'h3: rate_q <= 12'h398;
        3'h4: rate_q <= 12'h640;
        3'h5: rate_q <= 12'h960;
        3'h6: rate_q <= 12'hCE4;
        default: rate_q <= 12'h000;
      endcase
    end
  end

  assign cfg_o = cfg_q;
  assign conv_start_o = start_q;
  assign converting_o = (state_q == ACR_ST_CONV);
  assign pullup_en_o = pullup_q;
  assign mux_pos_o = mux_pos_q;
  assign mux_neg_o = mux_neg_q;
  assign mux_neg_gnd_o = mux_gnd_q;
  assign full_scale_mv_o = fs_q;
  assign rate_sps_o = rate_q;
  assign rate_valid_o = rate_ok_q;
  assign temp_sel_o = cfg_q[ACR_TEMP_BIT];
  assign cont_mode_o = ~cfg_q[ACR_MODE_BIT];

  chk_reset_value: assert property (
    @(posedge clk_i) sys_rst_i |=> cfg_q == ACR_CFG_RESET)
    else $error("configuration not at reset value");

  chk_ss_start: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (ss_req && state_q == ACR_ST_IDLE) |=> conv_start_o ##1 !conv_start_o)
    else $error("one-shot write did not start one conversion");

  chk_busy_ignore: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ACR_ST_CONV && !conv_done_i) |=> !conv_start_o)
    else $error("conversion restarted while busy");

  chk_fixed_bits: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    apply |=> cfg_o[ACR_SS_BIT] == ACR_SS_READ && (!$past(start) || converting_o))
    else $error("one-shot bit reads nonzero");

  chk_rsvd_one: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (apply && !lk.cfg_word[ACR_RSVD_BIT]) |=> cfg_o[ACR_RSVD_BIT] == ACR_RSVD_VALUE)
    else $error("reserved bit took written zero");

  chk_qual_update: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    apply |=> cfg_q[14:1] == $past(lk.cfg_word[14:1]))
    else $error("qualified word not applied");

  chk_nop_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (new_word && !qual_ok) |=> $stable(cfg_q))
    else $error("unqualified word changed configuration");

  chk_cont_restart: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ACR_ST_CONV && conv_done_i && !cfg_q[ACR_MODE_BIT] && !apply)
    |=> ##1 conv_start_o)
    else $error("continuous mode did not restart");

  chk_pullup_gate: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !cs_s2_q |=> !pullup_en_o)
    else $error("pull-up active while selected");
endmodule // acr_config

// ---- dv/acr_host_model.sv ----
// Host serial master model: mode 1 frames on its own link clock
`timescale 1ns/1ps
module acr_host_model (
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // Deselected data-in wanders so a stale level never passes for data
  always #100.3 if (cs_n_o) din_o = ~din_o;

  // Clock stands low outside frames; launch on rise, sample on fall
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    #3.7;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b1;
      din_o = tx[31 - i];
      #62.5;
      sclk_o = 1'b0;
      rx[31 - i] = dout_i;
      #62.5;
    end
    cs_n_o = 1'b1;
    // Deselect gap long enough for the register side to see select high
    #62.5;
  endtask
endmodule // acr_host_model

// ---- dv/testbench.sv ----
// Self-checking bench of the configuration register
`timescale 1ns/1ps
module testbench;
  import acr_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [15:0] result_i = 16'h0000;
  logic sclk, cs_n, din, dout, oe_n, pu, cst, cvt, gnd, rv, ts, cm;
  logic [15:0] cfg, cur, w, exp_v, exp_res = ACR_RESULT_RESET;
  logic [1:0] mp, mn;
  logic [12:0] fsmv;
  logic [11:0] rate;
  logic [31:0] rx;
  logic [15:0] lfsr = 16'h0057;
  logic cs_q = 1'b1;
  logic [1:0] qv [3] = '{2'h0, 2'h2, 2'h3};
  logic [15:0] fsv [8] = '{16'h1800, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0100,
                           16'h0100, 16'h0100};
  logic [15:0] rtv [8] = '{16'h0080, 16'h00FA, 16'h01EA, 16'h0398, 16'h0640, 16'h0960,
                           16'h0CE4, 16'h0000};
  int num_errors = 0;
  int checks = 0;
  int starts = 0;
  int cd = 0;
  int lat = 1200;
  int cyc = 0;
  int s0;

  acr_config dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .dout_oe_n_o(oe_n), .pullup_en_o(pu),
    .conv_done_i(conv_done_i), .result_i(result_i), .conv_start_o(cst), .converting_o(cvt),
    .cfg_o(cfg), .mux_pos_o(mp), .mux_neg_o(mn), .mux_neg_gnd_o(gnd), .full_scale_mv_o(fsmv),
    .rate_sps_o(rate), .rate_valid_o(rv), .temp_sel_o(ts), .cont_mode_o(cm));
  acr_host_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));

  always #4 clk_i = ~clk_i;

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // Converter stand-in: result arrives lat cycles after each start
  always @(posedge clk_i) begin
    conv_done_i <= (cd == 1);
    if (cd == 1) begin
      exp_v = rnd();
      result_i <= exp_v;
      // Capture follows select as the register side saw it one cycle back
      if (cs_q === 1'b1) exp_res = exp_v;
    end
    cs_q <= cs_n;
    if (cst === 1'b1) cd <= lat;
    else if (cd > 0) cd <= cd - 1;
    if (cst === 1'b1) starts <= starts + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      final_report;
    end
  end

  // Pin driven and pull-up off while selected
  always @(negedge sclk) begin
    if (cs_n === 1'b0) check({14'h0, oe_n, pu}, 16'h0000);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Decoders must follow the register value
  task automatic chk_cfg(input logic [15:0] e);
    logic [2:0] m;
    logic [1:0] p;
    logic [1:0] n;
    m = e[14:12];
    p = m[2] ? m[1:0] : (m == 3'h0 ? 2'h0 : m[1:0] - 2'h1);
    n = m[2] ? 2'h0 : (m == 3'h0 ? 2'h1 : 2'h3);
    repeat (10) @(posedge clk_i);
    check(cfg, e);
    check({3'h0, fsmv}, fsv[e[11:9]]);
    check({rv, 3'h0, rate}, {e[7:5] != 3'h7, 3'h0, rtv[e[7:5]][11:0]});
    check({11'h0, gnd, mp, m[2] ? 2'h0 : mn}, {11'h0, m[2], p, n});
    check({12'h0, oe_n, ts, cm, pu}, {12'h0, 1'b1, e[4], ~e[8], e[3]});
    cur = e;
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_cfg(ACR_CFG_RESET);
    // Every mux, gain and rate code, bits 4 and 0 random
    for (int k = 0; k < 8; k++) begin
      w = rnd();
      w[14:12] = 3'(k);
      w[11:9] = 3'(k);
      w[7:5] = 3'(k);
      w[3] = k[0];
      w[15] = 1'b0;
      w[8] = 1'b1;
      w[2:1] = ACR_QUAL_VALID;
      host_u.xfer({w, w}, 32, rx);
      check(rx[31:16], exp_res);
      check(rx[15:0], {1'b0, w[14:1], 1'b1});
      chk_cfg({1'b0, w[14:1], 1'b1});
    end
    foreach (qv[i]) begin
      w = rnd();
      w[2:1] = qv[i];
      host_u.xfer({w, w}, 32, rx);
      check(rx[15:0], cur);
      chk_cfg(cur);
    end
    host_u.xfer(32'hFFFFFFFF, 32, rx);
    chk_cfg(cur);
    host_u.xfer(32'h00000000, 32, rx);
    chk_cfg(cur);
    host_u.xfer({16'h048B, 16'h0000}, 15, rx);
    chk_cfg(cur);
    // One-shot, then a second one while the first still runs
    s0 = starts;
    host_u.xfer({16'h858B, 16'h0000}, 32, rx);
    check(16'(starts - s0), 16'h0001);
    check({15'h0, cvt}, 16'h0001);
    chk_cfg(16'h058B);
    host_u.xfer({16'h858B, 16'h0000}, 32, rx);
    check(16'(starts - s0), 16'h0001);
    for (int t = 0; t < 2000 && cvt !== 1'b0; t++) @(posedge clk_i);
    check({15'h0, cvt}, 16'h0000);
    host_u.xfer(32'h00000000, 32, rx);
    check(rx[31:16], exp_res);
    // Continuous mode keeps starting with select high
    lat = 40;
    s0 = starts;
    host_u.xfer({16'h048B, 16'h048B}, 32, rx);
    chk_cfg(16'h048B);
    repeat (200) @(posedge clk_i);
    check({15'h0, starts - s0 > 4}, 16'h0001);
    host_u.xfer({16'h058B, 16'h058B}, 32, rx);
    check(rx[31:16], exp_res);
    chk_cfg(16'h058B);
    final_report;
  end
endmodule // testbench
